// [src/pmcp_pkg.sv]
// pmcp_pkg: constants and types for program memory code protection
// assumes a flash array with a word-wide port and a config load sequencer
package pmcp_pkg;
    localparam int unsigned CFG_WORDS   = 2;
    localparam int unsigned CFG_W       = 16;
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned DATA_W      = 16;
    // config words live at the top of program memory
    localparam logic [15:0] CFG_BASE    = 16'hfffc;
    localparam int unsigned CFG_RCP_BIT = 0;
    localparam int unsigned CFG_WP_BIT  = 1;
    localparam int unsigned CFG_DBG_BIT = 2;
    localparam logic [15:0] CFG_RST_VAL = 16'hffff;
    localparam logic [15:0] DBG_RAM_TOP = 16'h0050;
    localparam int unsigned PAR_RST_CYC = 4;
    typedef enum logic [1:0] {
        PMCP_LOAD_REQ,
        PMCP_LOAD_WAIT,
        PMCP_RUN
    } pmcp_state_t;
endpackage

// [src/pmcp_if.sv]
// pmcp_if: one config register and its complement shadow
// assumes a single clock shared with pmcp_top
`timescale 1ns/10ps
`default_nettype none
interface pmcp_if;
    logic                        load;
    logic [pmcp_pkg::CFG_W-1:0]  load_val;
    logic [pmcp_pkg::CFG_W-1:0]  value;
    logic                        mismatch;
    modport owner (input load, input load_val, output value, output mismatch);
    modport user  (output load, output load_val, input value, input mismatch);
endinterface
`default_nettype wire

// [src/pmcp_shadow_reg.sv]
// pmcp_shadow_reg: config register with complement shadow and checker
// assumes load is a one-cycle pulse on clk
`timescale 1ns/10ps
`default_nettype none
module pmcp_shadow_reg (
    input  wire logic clk,
    input  wire logic sys_rst,
    pmcp_if.owner     port
);
    logic [pmcp_pkg::CFG_W-1:0] val_q,  val_d;
    logic [pmcp_pkg::CFG_W-1:0] shd_q,  shd_d;
    logic                       mis_q,  mis_d;

    always_comb
    begin
        val_d = val_q;
        shd_d = shd_q;
        if (port.load)
        begin
            val_d = port.load_val;
            shd_d = ~port.load_val;
        end
        // any cell flipping breaks the complement relation
        mis_d = ((val_q ^ shd_q) != {pmcp_pkg::CFG_W{1'b1}});
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            val_q <= pmcp_pkg::CFG_RST_VAL;
            shd_q <= ~pmcp_pkg::CFG_RST_VAL;
            mis_q <= 1'b0;
        end
        else
        begin
            val_q <= val_d;
            shd_q <= shd_d;
            mis_q <= mis_d;
        end
    end

    assign port.value    = val_q;
    assign port.mismatch = mis_q;
endmodule // pmcp_shadow_reg
`default_nettype wire

// [src/pmcp_top.sv]
// pmcp_top: program memory protection, config load, debug reservation
// assumes flash answers reads one or more cycles after fl_rd_req
`timescale 1ns/10ps
`default_nettype none
module pmcp_top (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // flash array port
    output logic                               fl_rd_req,
    output logic [pmcp_pkg::ADDR_W-1:0]        fl_addr,
    input  wire logic                          fl_rd_ack,
    input  wire logic [pmcp_pkg::DATA_W-1:0]   fl_rd_data,
    output logic                               fl_wr_en,
    output logic                               fl_erase_en,
    // external programming engine (serial side decoded elsewhere)
    input  wire logic                          ext_rd_req,
    input  wire logic                          ext_wr_req,
    input  wire logic [pmcp_pkg::DATA_W-1:0]   ext_rd_data_in,
    output logic [pmcp_pkg::DATA_W-1:0]        ext_rd_data,
    output logic                               ext_grant,
    output logic                               ext_denied,
    // internal self-programming requests
    input  wire logic                          int_wr_req,
    input  wire logic                          int_erase_req,
    // pins
    input  wire logic                          prog_serial_clock,
    input  wire logic                          prog_serial_data,
    input  wire logic                          debug_clock_pin,
    input  wire logic                          debug_data_pin,
    input  wire logic                          master_clear_pin_n,
    output logic                               prog_clk_s,
    output logic                               prog_data_s,
    output logic                               dbg_clk_s,
    output logic                               dbg_data_s,
    // state
    input  wire logic [pmcp_pkg::ADDR_W-1:0]   ram_addr,
    output logic                               ram_debug_hit,
    output logic                               debug_pins_owned,
    output logic                               global_read_protect,
    output logic                               global_write_protect,
    output logic                               cfg_ready,
    output logic                               parity_err,
    output logic                               dev_reset_req
);
    localparam int unsigned N = pmcp_pkg::CFG_WORDS;

    pmcp_if cfg [N] ();
    logic [N-1:0] mis;

    // load sequencer state, declared ahead of the load strobes that use it
    pmcp_pkg::pmcp_state_t st_q, st_d;
    logic [1:0] idx_q, idx_d;
    logic rdy_q, rdy_d;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_cfg
            pmcp_shadow_reg u_reg (
                .clk     (clk),
                .sys_rst (sys_rst),
                .port    (cfg[g])
            );
            assign cfg[g].load     = fl_rd_ack && (st_q == pmcp_pkg::PMCP_LOAD_WAIT)
                                     && (idx_q == 2'(g));
            assign cfg[g].load_val = fl_rd_data;
            assign mis[g]          = cfg[g].mismatch;
        end
    endgenerate

    logic [pmcp_pkg::CFG_W-1:0] cfg0;
    assign cfg0 = cfg[0].value;

    // load sequencer

    always_comb
    begin
        st_d  = st_q;
        idx_d = idx_q;
        rdy_d = rdy_q;
        case (st_q)
            pmcp_pkg::PMCP_LOAD_REQ:  st_d = pmcp_pkg::PMCP_LOAD_WAIT;
            pmcp_pkg::PMCP_LOAD_WAIT:
                if (fl_rd_ack)
                begin
                    if (idx_q == 2'(N - 1))
                    begin
                        st_d  = pmcp_pkg::PMCP_RUN;
                        rdy_d = 1'b1;
                    end
                    else
                    begin
                        idx_d = idx_q + 2'd1;
                        st_d  = pmcp_pkg::PMCP_LOAD_REQ;
                    end
                end
            pmcp_pkg::PMCP_RUN:       st_d = st_q;
            default:                  st_d = pmcp_pkg::PMCP_LOAD_REQ;
        endcase
    end

    // synchronisers: 3 stages, change accepted when stages 2 and 3 agree
    logic [4:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    logic [4:0] pins;
    assign pins = {master_clear_pin_n, debug_data_pin, debug_clock_pin,
                   prog_serial_data, prog_serial_clock};

    always_comb
    begin
        flt_d = flt_q;
        for (int i = 0; i < 5; i++)
            if (s2_q[i] == s3_q[i])
                flt_d[i] = s3_q[i];
    end

    // protection decisions
    logic rp, wp_n, dbg_en, ext_req, ext_ok;
    assign rp      = !rdy_q || cfg0[pmcp_pkg::CFG_RCP_BIT] == 1'b0;
    assign wp_n    = cfg0[pmcp_pkg::CFG_WP_BIT];
    assign dbg_en  = rdy_q && cfg0[pmcp_pkg::CFG_DBG_BIT] == 1'b0;
    assign ext_req = ext_rd_req || ext_wr_req;
    // address is not consulted: config words share the same gate
    assign ext_ok  = ext_req && !rp;

    logic [2:0] par_cnt_q, par_cnt_d;
    logic       perr_q, perr_d;
    always_comb
    begin
        perr_d    = perr_q || (|mis);
        par_cnt_d = par_cnt_q;
        if (|mis)
            par_cnt_d = 3'(pmcp_pkg::PAR_RST_CYC);
        else if (par_cnt_q != 3'd0)
            par_cnt_d = par_cnt_q - 3'd1;
    end

    // next values of the registered outputs
    logic                            rd_req_d, wr_en_d, erase_en_d;
    logic [pmcp_pkg::ADDR_W-1:0]     addr_d;
    logic [pmcp_pkg::DATA_W-1:0]     rd_data_d;
    logic                            grant_d, denied_d, ram_hit_d;
    logic                            dbg_own_d, grp_d, gwp_d, rst_req_d;
    always_comb
    begin
        rd_req_d   = (st_d == pmcp_pkg::PMCP_LOAD_REQ) ||
                     (st_d == pmcp_pkg::PMCP_LOAD_WAIT);
        addr_d     = pmcp_pkg::CFG_BASE + {14'h0000, idx_d};
        // write protect only gates self-programming, not the port
        wr_en_d    = (int_wr_req && wp_n && rdy_q) ||
                     (ext_wr_req && ext_ok);
        erase_en_d = int_erase_req && wp_n && rdy_q;
        // refused reads return zero and never see flash data
        rd_data_d  = (ext_rd_req && ext_ok) ? ext_rd_data_in
                                            : 16'h0000;
        grant_d    = ext_ok;
        denied_d   = ext_req && rp;
        ram_hit_d  = dbg_en && (ram_addr < pmcp_pkg::DBG_RAM_TOP);
        dbg_own_d  = dbg_en;
        grp_d      = rp;
        // writes protected until the load is done, as the write gate acts
        gwp_d      = !(wp_n && rdy_q);
        rst_req_d  = (|mis) || (par_cnt_q != 3'd0);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q   <= pmcp_pkg::PMCP_LOAD_REQ;
            idx_q  <= 2'd0;
            rdy_q  <= 1'b0;
            s1_q   <= 5'h10;
            s2_q   <= 5'h10;
            s3_q   <= 5'h10;
            flt_q  <= 5'h10;
            perr_q <= 1'b0;
            par_cnt_q <= 3'd0;
            fl_rd_req   <= 1'b0;
            fl_addr     <= pmcp_pkg::CFG_BASE;
            fl_wr_en    <= 1'b0;
            fl_erase_en <= 1'b0;
            ext_rd_data <= 16'h0000;
            ext_grant   <= 1'b0;
            ext_denied  <= 1'b0;
            ram_debug_hit    <= 1'b0;
            debug_pins_owned <= 1'b0;
            global_read_protect  <= 1'b1;
            global_write_protect <= 1'b1;
            dev_reset_req        <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            idx_q  <= idx_d;
            rdy_q  <= rdy_d;
            s1_q   <= pins;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            flt_q  <= flt_d;
            perr_q <= perr_d;
            par_cnt_q <= par_cnt_d;
            fl_rd_req   <= rd_req_d;
            fl_addr     <= addr_d;
            fl_wr_en    <= wr_en_d;
            fl_erase_en <= erase_en_d;
            ext_rd_data <= rd_data_d;
            ext_grant   <= grant_d;
            ext_denied  <= denied_d;
            ram_debug_hit    <= ram_hit_d;
            debug_pins_owned <= dbg_own_d;
            global_read_protect  <= grp_d;
            global_write_protect <= gwp_d;
            dev_reset_req <= rst_req_d;
        end
    end

    assign prog_clk_s  = flt_q[0];
    assign prog_data_s = flt_q[1];
    assign dbg_clk_s   = flt_q[2];
    assign dbg_data_s  = flt_q[3];
    assign cfg_ready   = rdy_q;
    assign parity_err  = perr_q;
endmodule // pmcp_top
`default_nettype wire

// [test/pmcp_flash_model.sv]
// pmcp_flash_model: program memory answering config word reads
// assumes fl_rd_req is held until the ack pulse
`timescale 1ns/10ps
`default_nettype none
module pmcp_flash_model (
    input  wire logic        clk,
    input  wire logic        fl_rd_req,
    input  wire logic [15:0] fl_addr,
    input  wire logic [15:0] cfg_word,
    output logic             fl_rd_ack,
    output logic [15:0]      fl_rd_data
);
    logic [1:0]  wait_q = 2'h0;
    logic        ack_q  = 1'b0;
    logic [15:0] data_q = 16'h0000;
    assign fl_rd_ack  = ack_q;
    assign fl_rd_data = data_q;
    // slow answer; data flips when not valid so a late latch shows
    always @(posedge clk)
    begin
        wait_q <= (fl_rd_req && !ack_q) ? wait_q + 2'h1 : 2'h0;
        ack_q  <= fl_rd_req && !ack_q && wait_q == 2'h2;
        data_q <= (fl_rd_req && wait_q == 2'h2) ?
            (fl_addr == pmcp_pkg::CFG_BASE ? cfg_word : 16'hffff) : ~data_q;
    end
endmodule // pmcp_flash_model
`default_nettype wire

// [test/pmcp_chk.sv]
// pmcp_chk: port assertions for pmcp_top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module pmcp_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ext_rd_req,
    input wire logic        ext_wr_req,
    input wire logic        int_wr_req,
    input wire logic        int_erase_req,
    input wire logic [15:0] ram_addr,
    input wire logic [15:0] ext_rd_data,
    input wire logic        ext_grant,
    input wire logic        ext_denied,
    input wire logic        fl_wr_en,
    input wire logic        fl_erase_en,
    input wire logic        ram_debug_hit,
    input wire logic        global_read_protect,
    input wire logic        global_write_protect,
    input wire logic        cfg_ready,
    input wire logic        parity_err,
    input wire logic        dev_reset_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ext_block_a: assert property ((ext_rd_req || ext_wr_req) ##1
        global_read_protect |-> ext_denied && !ext_grant)
        else $error("external access not refused");
    deny_zero_a: assert property (ext_denied |-> ext_rd_data == 16'h0000)
        else $error("refused read returned data");
    ext_open_a: assert property (ext_rd_req && !global_read_protect &&
        cfg_ready |=> ext_grant && !ext_denied)
        else $error("open read not granted");
    early_deny_a: assert property (!cfg_ready && ext_rd_req |=> !ext_grant)
        else $error("grant before config load");
    wr_block_a: assert property ((int_wr_req || int_erase_req) ##1
        global_write_protect |-> !fl_erase_en &&
        (!fl_wr_en || (ext_grant && $past(ext_wr_req))))
        else $error("internal write not blocked");
    wr_open_a: assert property (int_wr_req && !global_write_protect &&
        cfg_ready |=> fl_wr_en)
        else $error("internal write not passed");
    par_reset_a: assert property ($rose(parity_err) |-> dev_reset_req)
        else $error("parity error without reset");
    par_hold_a: assert property (parity_err |=> parity_err)
        else $error("parity flag dropped");
    ram_hit_a: assert property (ram_debug_hit |->
        $past(ram_addr) < pmcp_pkg::DBG_RAM_TOP)
        else $error("debug hit above reserved area");
    cover property (ext_grant);
    cover property (ext_denied);
    cover property (fl_wr_en);
    cover property (ram_debug_hit);
endmodule // pmcp_chk
bind pmcp_top pmcp_chk u_chk (.clk, .sys_rst, .ext_rd_req, .ext_wr_req,
    .int_wr_req, .int_erase_req, .ram_addr, .ext_rd_data, .ext_grant,
    .ext_denied, .fl_wr_en, .fl_erase_en, .ram_debug_hit,
    .global_read_protect, .global_write_protect, .cfg_ready, .parity_err,
    .dev_reset_req);
`default_nettype wire

// [test/pmcp_top_bench.sv]
// pmcp_top_bench: self-checking bench for pmcp_top
// assumes pmcp_flash_model stands on the flash port
`timescale 1ns/10ps
`default_nettype none
module pmcp_top_bench;
    logic clk = 1'b0, sys_rst = 1'b1, fl_rd_req, fl_rd_ack, fl_wr_en;
    logic fl_erase_en, ext_rd_req = 1'b0, ext_wr_req = 1'b0, ext_grant;
    logic ext_denied, int_wr_req = 1'b0, int_erase_req = 1'b0;
    logic [3:0]  pins = 4'h0;
    logic [15:0] fl_addr, fl_rd_data, ext_rd_data, cfg_word = 16'hffff;
    logic [15:0] ram_addr = 16'h0000;
    logic prog_clk_s, prog_data_s, dbg_clk_s, dbg_data_s, ram_debug_hit;
    logic debug_pins_owned, global_read_protect, global_write_protect;
    logic cfg_ready, parity_err, dev_reset_req;
    int   fail_count = 0, checks_done = 0, cycles = 0, n;
    always #12.5 clk = ~clk;
    pmcp_flash_model u_mem (.clk, .fl_rd_req, .fl_addr, .cfg_word,
        .fl_rd_ack, .fl_rd_data);
    pmcp_top u_dut (.clk, .sys_rst, .fl_rd_req, .fl_addr, .fl_rd_ack,
        .fl_rd_data, .fl_wr_en, .fl_erase_en, .ext_rd_req, .ext_wr_req,
        .ext_rd_data_in(16'h5a3c), .ext_rd_data, .ext_grant, .ext_denied,
        .int_wr_req, .int_erase_req, .prog_serial_clock(pins[3]),
        .prog_serial_data(pins[2]), .debug_clock_pin(pins[1]),
        .debug_data_pin(pins[0]), .master_clear_pin_n(1'b1), .prog_clk_s,
        .prog_data_s, .dbg_clk_s, .dbg_data_s, .ram_addr, .ram_debug_hit,
        .debug_pins_owned, .global_read_protect, .global_write_protect,
        .cfg_ready, .parity_err, .dev_reset_req);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        if (fail_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // a request raised at reset release must be refused during the load
    task automatic boot(input logic [15:0] w);
        @(posedge clk) sys_rst <= 1'b1;
        cfg_word <= w;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        ext_rd_req <= 1'b1;
        repeat (2) tick();
        check({14'h0, ext_denied, global_write_protect}, 16'h0003);
        for (n = 0; n < 60 && cfg_ready !== 1'b1; n++)
            tick();
        check({15'h0, cfg_ready}, 16'h0001);
        @(posedge clk) ext_rd_req <= 1'b0;
        // protect outputs lag the load by one register stage
        tick();
    endtask
    task automatic t_open();
        boot(16'hffff);
        check({14'h0, global_read_protect, global_write_protect},
            16'h0000);
        @(posedge clk) ext_rd_req <= 1'b1;
        tick();
        check({15'h0, ext_grant}, 16'h0001);
        check(ext_rd_data, 16'h5a3c);
        @(posedge clk) ext_rd_req <= 1'b0;
        int_wr_req <= 1'b1;
        int_erase_req <= 1'b1;
        tick();
        check({14'h0, fl_wr_en, fl_erase_en}, 16'h0003);
        @(posedge clk) int_wr_req <= 1'b0;
        int_erase_req <= 1'b0;
        tick();
        check({14'h0, debug_pins_owned, ram_debug_hit}, 16'h0000);
        check({14'h0, parity_err, dev_reset_req}, 16'h0000);
    endtask
    task automatic t_locked();
        boot(16'hfff8);
        check({14'h0, global_read_protect, global_write_protect},
            16'h0003);
        @(posedge clk) ext_rd_req <= 1'b1;
        ext_wr_req <= 1'b1;
        int_wr_req <= 1'b1;
        int_erase_req <= 1'b1;
        tick();
        check({14'h0, ext_denied, ext_grant}, 16'h0002);
        check(ext_rd_data, 16'h0000);
        check({14'h0, fl_wr_en, fl_erase_en}, 16'h0000);
        @(posedge clk) {ext_rd_req, ext_wr_req} <= 2'h0;
        {int_wr_req, int_erase_req} <= 2'h0;
        ram_addr <= 16'h004f;
        repeat (2) tick();
        check({14'h0, debug_pins_owned, ram_debug_hit}, 16'h0003);
        @(posedge clk) ram_addr <= 16'h0050;
        repeat (2) tick();
        check({15'h0, ram_debug_hit}, 16'h0000);
    endtask
    task automatic t_pins(input logic [3:0] v);
        @(posedge clk) pins <= v;
        repeat (6) tick();
        check({12'h0, prog_clk_s, prog_data_s, dbg_clk_s, dbg_data_s},
            {12'h0, v});
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        t_open();
        t_locked();
        t_pins(4'ha);
        t_pins(4'h5);
        test_done();
    end
endmodule // pmcp_top_bench
`default_nettype wire
